// [bench/msg_source.sv]
// Model of the protocol engine that hands over received identifiers
module msg_source (
  input logic clk,
  input logic reset,
  input logic req,
  input logic [10:0] req_sid,
  input logic [17:0] req_eid,
  input logic req_ext,
  output logic msg_valid,
  output logic [10:0] msg_sid,
  output logic [17:0] msg_eid,
  output logic msg_extended
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // One pulse per message, lines toggle when idle
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      msg_valid <= 1'b0;
      {msg_sid, msg_eid, msg_extended} <= '0;
    end else if (req) begin
      msg_valid <= 1'b1;
      {msg_sid, msg_eid, msg_extended} <= {req_sid, req_eid, req_ext};
    end else begin
      msg_valid <= 1'b0;
      {msg_sid, msg_eid, msg_extended} <= ~{msg_sid, msg_eid, msg_extended};
    end
  end
endmodule : msg_source

// [bench/test_can_acceptance_filter.sv]
// Self-checking bench for the CAN acceptance filter
`include "can_accept_regs.svh"
module test_can_acceptance_filter import can_accept_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  addr_type addr = '0;
  word_type wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  word_type rdata_q;
  logic msg_valid, msg_extended, store_valid_q;
  logic [10:0] msg_sid;
  logic [17:0] msg_eid;
  fifo_sel_type store_fifo_q;
  logic [1:0] store_filter_q;
  logic req = 1'b0;
  logic [10:0] req_sid = '0;
  logic [17:0] req_eid = '0;
  logic req_ext = 1'b0;
  int err_total = 0;
  int n_compared = 0;
  always #2.5 clk = ~clk;
  msg_source u_src (.clk(clk), .reset(reset), .req(req), .req_sid(req_sid),
    .req_eid(req_eid), .req_ext(req_ext), .msg_valid(msg_valid),
    .msg_sid(msg_sid), .msg_eid(msg_eid), .msg_extended(msg_extended));
  can_acceptance_filter u_dut (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .msg_valid(msg_valid), .msg_sid(msg_sid), .msg_eid(msg_eid),
    .msg_extended(msg_extended), .store_valid_q(store_valid_q),
    .store_fifo_q(store_fifo_q), .store_filter_q(store_filter_q));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string name, word_type exp, word_type got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", name, exp, got);
      err_total++;
    end
  endtask : chk
  task automatic wr(addr_type a, word_type d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(string name, addr_type a, word_type exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(name, exp, rdata_q);
  endtask : rd
  task automatic msg(logic [10:0] s, logic [17:0] e, logic x, logic [7:0] ex);
    logic [7:0] got;
    @(posedge clk);
    req <= 1'b1;
    req_sid <= s;
    req_eid <= e;
    req_ext <= x;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    got = {store_valid_q,
      store_valid_q ? {store_filter_q, store_fifo_q} : 7'h0};
    chk("store", {24'h0, ex}, {24'h0, got});
  endtask : msg
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mode;
    rd("mask0 reset", `OFS_ACCEPT_MASK0, '0);
    wr(`OFS_ACCEPT_MASK0, 32'hFFFF_FFFF);
    rd("mask0 locked", `OFS_ACCEPT_MASK0, '0);
    rd("unmapped", 8'hFC, '0);
    wr(`OFS_MAIN_CONTROL, {8'h00, 3'b100, 21'h0});
    wr(`OFS_ACCEPT_MASK0, 32'hFFFF_FFFF);
    rd("mask0 open", `OFS_ACCEPT_MASK0, 32'hFFEB_FFFF);
  endtask : t_mode
  task automatic t_setup;
    wr(`OFS_ACCEPT_MASK0, 32'hFFE8_0000);
    wr(`OFS_ACCEPT_MASK0 + 8'h04, 32'hFFE3_FFFF);
    wr(`OFS_ACCEPT_MASK0 + 8'h08, 32'h8000_0000);
    wr(`OFS_MAIN_CONTROL, '0);
    wr(`OFS_ACCEPT_MASK0 + 8'h0C, 32'hFFFF_FFFF);
    rd("mask3", `OFS_ACCEPT_MASK0 + 8'h0C, '0);
    wr(`OFS_FILTER_ID0, 32'h2460_0000);
    wr(`OFS_FILTER_ID0 + 8'h04, 32'h0AAA_ABCD);
    wr(`OFS_FILTER_ID0 + 8'h08, 32'hFFE8_0000);
    wr(`OFS_FILTER_CONTROL0, 32'h0009_A583);
    rd("fcon", `OFS_FILTER_CONTROL0, 32'h0009_A583);
  endtask : t_setup
  task automatic t_match;
    msg(11'h123, 18'h0, 1'b0, {1'b1, 2'd0, 5'd3});
    msg(11'h123, 18'h0, 1'b1, 8'h00);
    msg(11'h055, 18'h2ABCD, 1'b1, {1'b1, 2'd1, 5'd5});
    msg(11'h055, 18'h0ABCD, 1'b1, 8'h00);
    msg(11'h055, 18'h0, 1'b0, {1'b1, 2'd1, 5'd5});
    msg(11'h7FF, 18'h0, 1'b1, {1'b1, 2'd2, 5'd9});
    rd("status", `OFS_MATCH_STATUS, 32'h0001_0209);
    msg(11'h7FF, 18'h0, 1'b0, 8'h00);
  endtask : t_match
  task automatic t_lock;
    wr(`OFS_FILTER_CONTROL0, 32'h0008_C5E4);
    rd("fcon lock", `OFS_FILTER_CONTROL0, 32'h0009_A583);
    msg(11'h123, 18'h0, 1'b0, {1'b1, 2'd0, 5'd3});
  endtask : t_lock
  task automatic t_msel;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(`OFS_FILTER_CONTROL0, 32'h0009_A500);
      wr(`OFS_FILTER_CONTROL0, {11'h0, 5'd9, 8'hA5, 1'b1, c, 3'b011, c});
      msg(11'h0FF, 18'h1, 1'b1, c[1] ? {3'b100, 3'b011, c} : 8'h00);
    end
    wr(`OFS_FILTER_CONTROL0, 32'h0009_A500);
    wr(`OFS_FILTER_CONTROL0, 32'h0009_A5F0);
    msg(11'h0FF, 18'h1, 1'b1, 8'h00);
    wr(`OFS_FILTER_CONTROL0, 32'h0009_2570);
    msg(11'h055, 18'h2ABCD, 1'b1, 8'h00);
    msg(11'h7FF, 18'h0, 1'b1, 8'h00);
  endtask : t_msel
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_mode();
    t_setup();
    t_match();
    t_lock();
    t_msel();
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : test_can_acceptance_filter

// [src/can_accept_pkg.sv]
// Types shared by the acceptance filter files
package can_accept_pkg;
  typedef logic [31:0] word_type;
  typedef logic [7:0] addr_type;
  typedef logic [1:0] mask_sel_type;
  typedef logic [4:0] fifo_sel_type;
  typedef enum {ST_IDLE, ST_DELIVER} match_state_type;
endpackage : can_accept_pkg

// [src/can_accept_regs.svh]
// Register offsets, field positions and reset values of the acceptance filter
`ifndef CAN_ACCEPT_REGS_SVH
`define CAN_ACCEPT_REGS_SVH

`define OFS_MAIN_CONTROL 8'h00
`define OFS_ACCEPT_MASK0 8'h04
`define OFS_FILTER_CONTROL0 8'h14
`define OFS_FILTER_ID0 8'h18
`define OFS_MATCH_STATUS 8'h24
`define OPFIELD_HI 23
`define OPFIELD_LO 21
`define OPFIELD_CONFIG 3'b100
`define MASK_STD_HI 31
`define MASK_STD_LO 21
`define MASK_TYPE_BIT 19
`define MASK_EXT_HI 17
`define MASK_EXT_LO 0
`define MASK_WRITABLE 32'hFFEB_FFFF
`define FILT_EXT_BIT 19
`define FILT_WRITABLE 32'hFFEB_FFFF
`define FLT_STRIDE 8
`define FLT_EN_OFS 7
`define FLT_MSEL_OFS 5
`define FSEL_RESERVED_BIT 4
`define FCON_WRITABLE 32'h001F_FFFF
`define RESET_WORD 32'h0000_0000

`endif

// [src/can_acceptance_filter.sv]
// CAN acceptance filter with mask, filter and control registers
`include "can_accept_regs.svh"

module can_acceptance_filter (
  input wire logic clk,
  input wire logic reset,
  input wire can_accept_pkg::addr_type addr,
  input wire can_accept_pkg::word_type wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output can_accept_pkg::word_type rdata_q,
  input wire logic msg_valid,
  input wire logic [10:0] msg_sid,
  input wire logic [17:0] msg_eid,
  input wire logic msg_extended,
  output logic store_valid_q,
  output can_accept_pkg::fifo_sel_type store_fifo_q,
  output logic [1:0] store_filter_q
);
  import can_accept_pkg::*;

  localparam int NUM_FILTERS = 3;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  word_type can_main_control_reg_q;
  word_type mask_q [4];
  word_type can_filter_control_0_q;
  word_type filt_id_q [NUM_FILTERS];
  word_type status_q;
  logic config_mode;
  logic [NUM_FILTERS-1:0] filt_on;
  logic [NUM_FILTERS-1:0] hit;
  word_type fcon_wr;
  logic vld_q;
  match_state_type state_q;

  assign config_mode =
    can_main_control_reg_q[`OPFIELD_HI:`OPFIELD_LO] == `OPFIELD_CONFIG;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      can_main_control_reg_q <= `RESET_WORD;
    end else if (wr_en && addr == `OFS_MAIN_CONTROL) begin
      can_main_control_reg_q <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Mask registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        mask_q[i] <= `RESET_WORD;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_en && config_mode &&
            addr == `OFS_ACCEPT_MASK0 + 8'(4 * i)) begin
          mask_q[i] <= wdata & `MASK_WRITABLE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Filter identifier registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        filt_id_q[i] <= `RESET_WORD;
      end
    end else begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        if (wr_en && !filt_on[i] &&
            addr == `OFS_FILTER_ID0 + 8'(4 * i)) begin
          filt_id_q[i] <= wdata & `FILT_WRITABLE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Filter control word
  // ---------------------------------------------------------------
  assign fcon_wr = wdata & `FCON_WRITABLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      can_filter_control_0_q <= `RESET_WORD;
    end else if (wr_en && addr == `OFS_FILTER_CONTROL0) begin
      for (int f = 0; f < NUM_FILTERS; f++) begin
        // Enable bit of filters 0 and 1 always writable; select fields only when off
        if (!filt_on[f]) begin
          can_filter_control_0_q[f*`FLT_STRIDE +: 7] <=
            fcon_wr[f*`FLT_STRIDE +: 7];
        end
        if (f < 2) begin
          can_filter_control_0_q[f*`FLT_STRIDE+`FLT_EN_OFS] <=
            fcon_wr[f*`FLT_STRIDE+`FLT_EN_OFS];
        end
      end
    end
  end

  // Filter 2 owns only its FIFO select here, so it follows filter 1 enable
  assign filt_on[0] = can_filter_control_0_q[7];
  assign filt_on[1] = can_filter_control_0_q[15];
  assign filt_on[2] = can_filter_control_0_q[15];

  // ---------------------------------------------------------------
  // Message capture and compare
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vld_q <= 1'b0;
    end else begin
      vld_q <= msg_valid;
    end
  end

  for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_filter
    logic [1:0] msel;
    assign msel = (g < 2) ?
      can_filter_control_0_q[g*`FLT_STRIDE+`FLT_MSEL_OFS +: 2] : 2'b00;
    filter_compare u_cmp (
      .clk(clk),
      .reset(reset),
      .enable(filt_on[g] && msg_valid),
      .mask_word(mask_q[msel]),
      .filter_word(filt_id_q[g]),
      .msg_sid(msg_sid),
      .msg_eid(msg_eid),
      .msg_extended(msg_extended),
      .hit_q(hit[g])
    );
  end

  // ---------------------------------------------------------------
  // Delivery to receive FIFO
  // ---------------------------------------------------------------
  logic [1:0] win;
  fifo_sel_type win_fsel;
  logic win_ok;
  always_comb begin
    win = 2'd0;
    win_ok = 1'b0;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        win = 2'(i);
        win_ok = 1'b1;
      end
    end
    win_fsel = can_filter_control_0_q[win*`FLT_STRIDE +: 5];
    // Reserved FIFO codes never store
    if (win_fsel[`FSEL_RESERVED_BIT]) begin
      win_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      store_valid_q <= 1'b0;
      store_fifo_q <= 5'h00;
      store_filter_q <= 2'b00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          store_valid_q <= vld_q && win_ok;
          store_fifo_q <= win_fsel;
          store_filter_q <= win;
          if (vld_q && win_ok) begin
            state_q <= ST_DELIVER;
          end
        end
        ST_DELIVER: begin
          store_valid_q <= vld_q && win_ok;
          store_fifo_q <= win_fsel;
          store_filter_q <= win;
          if (!(vld_q && win_ok)) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= `RESET_WORD;
    end else if (vld_q) begin
      status_q <= {15'h0000, win_ok, 6'h00, win, 3'h0, win_fsel};
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= `RESET_WORD;
    end else if (rd_en) begin
      case (addr)
        `OFS_MAIN_CONTROL: rdata_q <= can_main_control_reg_q;
        8'h04: rdata_q <= mask_q[0];
        8'h08: rdata_q <= mask_q[1];
        8'h0C: rdata_q <= mask_q[2];
        8'h10: rdata_q <= mask_q[3];
        `OFS_FILTER_CONTROL0: rdata_q <= can_filter_control_0_q;
        8'h18: rdata_q <= filt_id_q[0];
        8'h1C: rdata_q <= filt_id_q[1];
        8'h20: rdata_q <= filt_id_q[2];
        `OFS_MATCH_STATUS: rdata_q <= status_q;
        default: rdata_q <= `RESET_WORD;
      endcase
    end else begin
      rdata_q <= `RESET_WORD;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_mask_locked: assert property (@(posedge clk) disable iff (reset)
    (wr_en && addr == 8'h04 && !config_mode) |=> $stable(mask_q[0]))
    else $error("mask changed outside configuration");
  a_mask_takes: assert property (@(posedge clk) disable iff (reset)
    (wr_en && addr == 8'h04 && config_mode) |=>
    mask_q[0] == ($past(wdata) & `MASK_WRITABLE))
    else $error("mask write lost");
  a_sel_locked: assert property (@(posedge clk) disable iff (reset)
    (wr_en && addr == `OFS_FILTER_CONTROL0 && filt_on[0]) |=>
    $stable(can_filter_control_0_q[6:0]))
    else $error("filter 0 fields changed while on");
  a_enable_bit: assert property (@(posedge clk) disable iff (reset)
    (wr_en && addr == `OFS_FILTER_CONTROL0) |=>
    filt_on[1] == $past(wdata[15]))
    else $error("filter 1 enable not written");
  a_no_reserved: assert property (@(posedge clk) disable iff (reset)
    store_valid_q |-> !store_fifo_q[4])
    else $error("reserved fifo used");
  a_store_cause: assert property (@(posedge clk) disable iff (reset)
    store_valid_q |-> $past(vld_q, 1) && $past(msg_valid, 2))
    else $error("store without message");
  a_off_silent: assert property (@(posedge clk) disable iff (reset)
    (msg_valid && !filt_on[0]) |=> !hit[0])
    else $error("disabled filter hit");
  a_read_zero: assert property (@(posedge clk) disable iff (reset)
    (rd_en && addr == 8'hFC) |=> rdata_q == 32'h0000_0000)
    else $error("unmapped read not zero");
  c_store: cover property (@(posedge clk) store_valid_q);
  c_back_to_back: cover property (@(posedge clk)
    store_valid_q ##1 store_valid_q);
  c_mask_write: cover property (@(posedge clk) wr_en && config_mode);
endmodule : can_acceptance_filter

// [src/filter_compare.sv]
// One filter: masked identifier compare with frame type check
module filter_compare (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic [31:0] mask_word,
  input wire logic [31:0] filter_word,
  input wire logic [10:0] msg_sid,
  input wire logic [17:0] msg_eid,
  input wire logic msg_extended,
  output logic hit_q
);
  logic [10:0] standard_id_mask_bits;
  logic [17:0] extended_id_mask_bits;
  logic id_type_match_enable;
  logic filter_extended_flag;
  logic sid_ok;
  logic eid_ok;
  logic type_ok;
  logic hit_d;

  assign standard_id_mask_bits = mask_word[31:21];
  assign extended_id_mask_bits = mask_word[17:0];
  assign id_type_match_enable = mask_word[19];
  assign filter_extended_flag = filter_word[19];
  // Clear mask bits are don't care
  assign sid_ok = ((msg_sid ^ filter_word[31:21]) & standard_id_mask_bits)
    == 11'h000;
  assign eid_ok = ((msg_eid ^ filter_word[17:0]) & extended_id_mask_bits)
    == 18'h0_0000;
  // Standard frames compare identifier only on the standard part
  assign type_ok = id_type_match_enable ?
    (msg_extended == filter_extended_flag) : 1'b1;
  assign hit_d = enable && sid_ok && type_ok &&
    (eid_ok || !msg_extended);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  a_type_gate: assert property (@(posedge clk) disable iff (reset)
    (enable && mask_word[19] && msg_extended != filter_word[19])
    |=> !hit_q) else $error("frame type mismatch accepted");
endmodule : filter_compare
